// *** shared/hdp_pkg.sv ***
package hdp_pkg;
    localparam int BYTE_W = 8;
    localparam int CRC_W = 16;
    localparam int CMP_N = 4;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT_CNT = 4'h7;
    localparam logic [1:0] POLY_CCITT = 2'h3;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT_ONES = 16'hFFFF;
    localparam logic [15:0] CRC_INIT_ZERO = 16'h0000;
    localparam int FLAG_CMP_IDX = 3;
    localparam logic [3:0] XFER_DIV_CYCLES = 4'h4;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h1,
        TX_SHIFT = 3'h2,
        TX_HOLD = 3'h4
    } hdp_tx_state_t;

    // one serial step of x^16+x^12+x^5+1
    function automatic logic [15:0] hdp_crc_step(input logic [15:0] crc,
                                                 input logic din);
        logic fb;
        fb = crc[15] ^ din;
        hdp_crc_step = {crc[14:0], 1'h0} ^ (fb ? CRC_POLY : CRC_INIT_ZERO);
    endfunction : hdp_crc_step

    // set mask bits are left out of the comparison
    function automatic logic hdp_hit(input logic [7:0] data,
                                     input logic [7:0] pattern,
                                     input logic [7:0] mask);
        hdp_hit = ((data ^ pattern) & ~mask) == 8'h00;
    endfunction : hdp_hit
endpackage : hdp_pkg

// *** core/hdp_unit.sv ***
`timescale 1ns/100ps
module hdp_unit (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic tx_enable_bit,
    input wire logic rx_enable_bit,
    input wire logic tx_irq_source_select,
    input wire logic tx_check_enable,
    input wire logic rx_check_enable,
    input wire logic auto_check_reset,
    input wire logic [1:0] poly_select,
    input wire logic crc_initial_value_select,
    input wire logic lsb_first,
    input wire logic tx_buffer_wr,
    input wire logic [hdp_pkg::BYTE_W-1:0] tx_buffer_wdata,
    input wire logic rx_input_wr,
    input wire logic [hdp_pkg::BYTE_W-1:0] rx_input_wdata,
    input wire logic tx_output_rd,
    input wire logic rx_buffer_rd,
    input wire logic [hdp_pkg::CMP_N-1:0] compare_enable,
    input wire logic [hdp_pkg::BYTE_W-1:0] pattern_compare_register0,
    input wire logic [hdp_pkg::BYTE_W-1:0] pattern_compare_register1,
    input wire logic [hdp_pkg::BYTE_W-1:0] pattern_compare_register2,
    input wire logic [hdp_pkg::BYTE_W-1:0] fourth_compare_register,
    input wire logic [hdp_pkg::BYTE_W-1:0] pattern_mask_register0,
    input wire logic [hdp_pkg::BYTE_W-1:0] pattern_mask_register1,
    input wire logic [hdp_pkg::BYTE_W-1:0] pattern_mask_register2,
    input wire logic [hdp_pkg::BYTE_W-1:0] pattern_mask_register3,
    output logic [hdp_pkg::BYTE_W-1:0] tx_buffer_register,
    output logic tx_buffer_full,
    output logic [hdp_pkg::BYTE_W-1:0] tx_output_register,
    output logic tx_output_full,
    output logic [hdp_pkg::BYTE_W-1:0] rx_buffer_register,
    output logic rx_buffer_full,
    output logic rx_input_full,
    output logic [hdp_pkg::CRC_W-1:0] tx_check_result,
    output logic [hdp_pkg::CRC_W-1:0] rx_check_result,
    output logic tx_irq_request,
    output logic rx_irq_request,
    output logic special_comm_irq_request
);
    import hdp_pkg::*;

    logic [3:0] div_reg, div_next;
    logic tick_reg, tick_next;
    hdp_tx_state_t tx_state_reg, tx_state_next;
    logic [7:0] tx_sh_reg, tx_sh_next, tx_asm_reg, tx_asm_next;
    logic [3:0] tx_bits_reg, tx_bits_next, tx_acnt_reg, tx_acnt_next;
    logic [2:0] tx_ones_reg, tx_ones_next;
    logic [15:0] tx_crc_reg, tx_crc_next;
    logic [7:0] tx_out_next, tx_buf_next;
    logic tx_out_full_next, tx_buf_full_next, tx_irq_next, tx_bit;
    logic [15:0] tx_chk_next, rx_chk_next;
    logic [7:0] rx_in_reg, rx_in_next, rx_sh_reg, rx_sh_next;
    logic [7:0] rx_asm_reg, rx_asm_next, rx_out_next;
    logic [3:0] rx_bits_reg, rx_bits_next, rx_acnt_reg, rx_acnt_next;
    logic [2:0] rx_ones_reg, rx_ones_next;
    logic [15:0] rx_crc_reg, rx_crc_next;
    logic rx_in_full_next, rx_out_full_next, rx_irq_next, spec_next;
    logic rx_bit, rx_keep;
    logic tx_load, rx_load, cmp_go;
    logic [15:0] crc_init;
    logic [7:0] cmp_byte;
    logic [3:0] hits;
    logic [3:0][7:0] cmp_pack, msk_pack;

    assign crc_init = crc_initial_value_select ? CRC_INIT_ONES
                                               : CRC_INIT_ZERO;
    assign tx_load = (tx_state_reg == TX_IDLE) && tx_enable_bit
                     && tx_buffer_full;
    assign rx_load = rx_enable_bit && rx_input_full
                     && (rx_bits_reg == 4'h0);
    assign cmp_pack = {fourth_compare_register, pattern_compare_register2,
                       pattern_compare_register1, pattern_compare_register0};
    assign msk_pack = {pattern_mask_register3, pattern_mask_register2,
                       pattern_mask_register1, pattern_mask_register0};
    assign cmp_go = tx_load || rx_load;
    assign cmp_byte = rx_load ? rx_in_reg : tx_buffer_register;

    // transfer clock enable divider
    always_comb begin
        div_next = div_reg + 4'h1;
        tick_next = 1'h0;
        if (div_reg == XFER_DIV_CYCLES - 4'h1) begin
            div_next = 4'h0;
            tick_next = 1'h1;
        end
    end

    // transmit path
    always_comb begin
        tx_state_next = tx_state_reg;
        tx_sh_next = tx_sh_reg;
        tx_bits_next = tx_bits_reg;
        tx_ones_next = tx_ones_reg;
        tx_asm_next = tx_asm_reg;
        tx_acnt_next = tx_acnt_reg;
        tx_crc_next = tx_crc_reg;
        tx_out_next = tx_output_register;
        tx_out_full_next = tx_output_full;
        tx_buf_next = tx_buffer_register;
        tx_buf_full_next = tx_buffer_full;
        tx_chk_next = tx_check_result;
        tx_irq_next = 1'h0;
        tx_bit = 1'h0;
        if (tx_output_rd && tx_output_full) begin
            tx_out_full_next = 1'h0;
            tx_irq_next = 1'h1;
        end
        unique case (tx_state_reg)
            TX_IDLE: begin
                if (tx_load) begin
                    tx_sh_next = tx_buffer_register;
                    tx_bits_next = BITS_PER_BYTE;
                    tx_buf_full_next = 1'h0;
                    tx_state_next = TX_SHIFT;
                    if (!tx_irq_source_select) begin
                        tx_irq_next = 1'h1;
                    end
                end
            end
            TX_SHIFT: begin
                if (tick_reg) begin
                    if (tx_ones_reg == STUFF_RUN) begin
                        tx_ones_next = 3'h0;
                    end else begin
                        tx_bit = lsb_first ? tx_sh_reg[0] : tx_sh_reg[7];
                        tx_sh_next = lsb_first ? {1'h0, tx_sh_reg[7:1]}
                                               : {tx_sh_reg[6:0], 1'h0};
                        tx_bits_next = tx_bits_reg - 4'h1;
                        tx_ones_next = tx_bit ? tx_ones_reg + 3'h1 : 3'h0;
                        if (poly_select == POLY_CCITT) begin
                            tx_crc_next = hdp_crc_step(tx_crc_reg, tx_bit);
                        end
                    end
                    tx_asm_next = lsb_first ? {tx_bit, tx_asm_reg[7:1]}
                                            : {tx_asm_reg[6:0], tx_bit};
                    tx_acnt_next = tx_acnt_reg + 4'h1;
                    if (tx_acnt_reg == LAST_BIT_CNT) begin
                        if (!tx_output_full) begin
                            tx_out_next = tx_asm_next;
                            tx_out_full_next = 1'h1;
                            tx_acnt_next = 4'h0;
                            tx_irq_next = tx_irq_next
                                          | tx_irq_source_select;
                        end else begin
                            tx_state_next = TX_HOLD;
                        end
                    end
                    if (tx_state_next != TX_HOLD && tx_bits_next == 4'h0
                        && tx_ones_next != STUFF_RUN) begin
                        tx_state_next = TX_IDLE;
                    end
                end
            end
            TX_HOLD: begin
                // resume only once the read has emptied the register
                if (!tx_output_full) begin
                    tx_out_next = tx_asm_reg;
                    tx_out_full_next = 1'h1;
                    tx_acnt_next = 4'h0;
                    tx_irq_next = tx_irq_next | tx_irq_source_select;
                    tx_state_next = (tx_bits_reg != 4'h0
                                     || tx_ones_reg == STUFF_RUN)
                                    ? TX_SHIFT : TX_IDLE;
                end
            end
            default: tx_state_next = TX_IDLE;
        endcase
        if (tx_buffer_wr) begin
            tx_buf_next = tx_buffer_wdata;
            tx_buf_full_next = 1'h1;
        end else if (rx_load) begin
            tx_buf_next = rx_in_reg;
        end
        if (!tx_enable_bit) begin
            tx_state_next = TX_IDLE;
            tx_bits_next = 4'h0;
            tx_ones_next = 3'h0;
            tx_crc_next = crc_init;
        end
        if (tx_check_enable) begin
            tx_chk_next = tx_crc_next;
        end
    end

    // receive path and pattern comparison
    always_comb begin
        rx_in_next = rx_in_reg;
        rx_in_full_next = rx_input_full;
        rx_sh_next = rx_sh_reg;
        rx_bits_next = rx_bits_reg;
        rx_ones_next = rx_ones_reg;
        rx_asm_next = rx_asm_reg;
        rx_acnt_next = rx_acnt_reg;
        rx_crc_next = rx_crc_reg;
        rx_out_next = rx_buffer_register;
        rx_out_full_next = rx_buffer_full;
        rx_chk_next = rx_check_result;
        rx_irq_next = 1'h0;
        rx_bit = 1'h0;
        rx_keep = 1'h0;
        for (int j = 0; j < CMP_N; j++) begin
            hits[j] = compare_enable[j]
                      && hdp_hit(cmp_byte, cmp_pack[j], msk_pack[j]);
        end
        spec_next = cmp_go && (hits != 4'h0);
        if (rx_buffer_rd) begin
            rx_out_full_next = 1'h0;
        end
        if (rx_load) begin
            rx_sh_next = rx_in_reg;
            rx_bits_next = BITS_PER_BYTE;
            rx_in_full_next = 1'h0;
            rx_irq_next = 1'h1;
            if (auto_check_reset && hits[FLAG_CMP_IDX]) begin
                rx_crc_next = crc_init;
            end
        end else if (tick_reg && rx_bits_reg != 4'h0) begin
            rx_bit = lsb_first ? rx_sh_reg[0] : rx_sh_reg[7];
            rx_sh_next = lsb_first ? {1'h0, rx_sh_reg[7:1]}
                                   : {rx_sh_reg[6:0], 1'h0};
            rx_bits_next = rx_bits_reg - 4'h1;
            rx_keep = !(rx_ones_reg == STUFF_RUN && !rx_bit);
            if (!rx_keep) begin
                rx_ones_next = 3'h0;
            end else begin
                rx_ones_next = !rx_bit ? 3'h0 : (rx_ones_reg == STUFF_RUN)
                               ? STUFF_RUN : rx_ones_reg + 3'h1;
                if (poly_select == POLY_CCITT) begin
                    rx_crc_next = hdp_crc_step(rx_crc_reg, rx_bit);
                end
                rx_asm_next = lsb_first ? {rx_bit, rx_asm_reg[7:1]}
                                        : {rx_asm_reg[6:0], rx_bit};
                rx_acnt_next = rx_acnt_reg + 4'h1;
                if (rx_acnt_reg == LAST_BIT_CNT) begin
                    rx_out_next = rx_asm_next;
                    rx_out_full_next = 1'h1;
                    rx_acnt_next = 4'h0;
                    rx_irq_next = 1'h1;
                end
            end
        end
        if (rx_input_wr) begin
            rx_in_next = rx_input_wdata;
            rx_in_full_next = 1'h1;
        end
        if (!rx_enable_bit) begin
            rx_bits_next = 4'h0;
            rx_ones_next = 3'h0;
        end
        if (rx_check_enable) begin
            rx_chk_next = rx_crc_next;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_reg <= 4'h0;
            tick_reg <= 1'h0;
            tx_state_reg <= TX_IDLE;
            tx_sh_reg <= 8'h00;
            tx_bits_reg <= 4'h0;
            tx_ones_reg <= 3'h0;
            tx_asm_reg <= 8'h00;
            tx_acnt_reg <= 4'h0;
            tx_crc_reg <= CRC_INIT_ZERO;
            tx_output_register <= 8'h00;
            tx_output_full <= 1'h0;
            tx_buffer_register <= 8'h00;
            tx_buffer_full <= 1'h0;
            tx_check_result <= CRC_INIT_ZERO;
            tx_irq_request <= 1'h0;
            rx_in_reg <= 8'h00;
            rx_input_full <= 1'h0;
            rx_sh_reg <= 8'h00;
            rx_bits_reg <= 4'h0;
            rx_ones_reg <= 3'h0;
            rx_asm_reg <= 8'h00;
            rx_acnt_reg <= 4'h0;
            rx_crc_reg <= CRC_INIT_ZERO;
            rx_buffer_register <= 8'h00;
            rx_buffer_full <= 1'h0;
            rx_check_result <= CRC_INIT_ZERO;
            rx_irq_request <= 1'h0;
            special_comm_irq_request <= 1'h0;
        end else begin
            div_reg <= div_next;
            tick_reg <= tick_next;
            tx_state_reg <= tx_state_next;
            tx_sh_reg <= tx_sh_next;
            tx_bits_reg <= tx_bits_next;
            tx_ones_reg <= tx_ones_next;
            tx_asm_reg <= tx_asm_next;
            tx_acnt_reg <= tx_acnt_next;
            tx_crc_reg <= tx_crc_next;
            tx_output_register <= tx_out_next;
            tx_output_full <= tx_out_full_next;
            tx_buffer_register <= tx_buf_next;
            tx_buffer_full <= tx_buf_full_next;
            tx_check_result <= tx_chk_next;
            tx_irq_request <= tx_irq_next;
            rx_in_reg <= rx_in_next;
            rx_input_full <= rx_in_full_next;
            rx_sh_reg <= rx_sh_next;
            rx_bits_reg <= rx_bits_next;
            rx_ones_reg <= rx_ones_next;
            rx_asm_reg <= rx_asm_next;
            rx_acnt_reg <= rx_acnt_next;
            rx_crc_reg <= rx_crc_next;
            rx_buffer_register <= rx_out_next;
            rx_buffer_full <= rx_out_full_next;
            rx_check_result <= rx_chk_next;
            rx_irq_request <= rx_irq_next;
            special_comm_irq_request <= spec_next;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence s_tx_loaded;
        ##1 (tx_state_reg == TX_SHIFT) && (tx_bits_reg == BITS_PER_BYTE);
    endsequence
    sequence s_rx_loaded;
        ##1 (rx_bits_reg == BITS_PER_BYTE) && rx_irq_request;
    endsequence

    property p_tx_start;
        tx_load |-> s_tx_loaded;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("tx did not start");
    property p_rx_start;
        rx_load |-> s_rx_loaded
                    ##0 (tx_buffer_register == $past(rx_in_reg));
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("rx did not start");
    property p_tx_stuff;
        (tx_state_reg == TX_SHIFT && tick_reg && tx_ones_reg == STUFF_RUN
         && tx_enable_bit) |=> tx_bits_reg == $past(tx_bits_reg)
                               && tx_ones_reg == 3'h0;
    endproperty
    a_tx_stuff: assert property (p_tx_stuff) else $error("no stuff bit");
    property p_rx_destuff;
        (tick_reg && !rx_load && rx_bits_reg != 4'h0 && rx_enable_bit
         && rx_ones_reg == STUFF_RUN && !rx_bit)
        |=> rx_acnt_reg == $past(rx_acnt_reg) && !rx_irq_request;
    endproperty
    a_rx_destuff: assert property (p_rx_destuff) else $error("zero kept");
    property p_tx_crc_reset;
        !tx_enable_bit |=> tx_crc_reg == $past(crc_init) [*2];
    endproperty
    a_tx_crc_reset: assert property (p_tx_crc_reset) else $error("crc kept");
    property p_tx_irq_load;
        (tx_load && !tx_irq_source_select) |=> tx_irq_request;
    endproperty
    a_tx_irq_load: assert property (p_tx_irq_load) else $error("no tx irq");
    property p_rx_done;
        (rx_irq_request && $changed(rx_buffer_register)) |-> rx_buffer_full;
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("rx not full");
    property p_flag_reset;
        (rx_load && auto_check_reset && hits[FLAG_CMP_IDX])
        |=> rx_crc_reg == $past(crc_init);
    endproperty
    a_flag_reset: assert property (p_flag_reset) else $error("no crc reset");
    property p_hold;
        (tx_state_reg == TX_HOLD && tx_output_full && !tx_output_rd
         && tx_enable_bit) |=> tx_state_reg == TX_HOLD
                               && $stable(tx_output_register);
    endproperty
    a_hold: assert property (p_hold) else $error("hold broken");
    property p_special;
        (cmp_go && hits != 4'h0) |=> special_comm_irq_request;
    endproperty
    a_special: assert property (p_special) else $error("no special irq");
endmodule : hdp_unit

// *** test/test_hdlc_data_processing_unit.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_hdlc_data_processing_unit;
    import hdp_pkg::*;
    logic sys_clk = 0;
    logic reset_n = 0;
    logic tx_enable_bit, rx_enable_bit, tx_irq_source_select, lsb_first;
    logic tx_check_enable, rx_check_enable, auto_check_reset;
    logic crc_initial_value_select, tx_buffer_wr, rx_input_wr;
    logic tx_output_rd, rx_buffer_rd;
    logic [1:0] poly_select;
    logic [3:0] compare_enable;
    logic [7:0] tx_buffer_wdata, rx_input_wdata, tx_buffer_register, ev;
    logic [7:0] tx_output_register, rx_buffer_register, pat[4], msk[4];
    logic tx_buffer_full, tx_output_full, rx_buffer_full, rx_input_full;
    logic tx_irq_request, rx_irq_request, special_comm_irq_request;
    logic [15:0] tx_check_result, rx_check_result, tcrc, rcrc;
    logic [7:0] q_txo[$], q_rxb[$], q_cpy[$], t_acc, r_acc;
    int n_fail, compares, cyc, t_n, r_n, t_ones, r_ones;
    int n_ti, n_ri, n_sp, e_ti, e_ri, e_sp;
    bit hold_rd, p_rif, p_tbf;

    hdp_unit DUT (.sys_clk, .reset_n, .tx_enable_bit, .rx_enable_bit,
        .tx_irq_source_select, .tx_check_enable, .rx_check_enable,
        .auto_check_reset, .poly_select, .crc_initial_value_select,
        .lsb_first, .tx_buffer_wr, .tx_buffer_wdata, .rx_input_wr,
        .rx_input_wdata, .tx_output_rd, .rx_buffer_rd, .compare_enable,
        .pattern_compare_register0(pat[0]),
        .pattern_compare_register1(pat[1]),
        .pattern_compare_register2(pat[2]),
        .fourth_compare_register(pat[3]),
        .pattern_mask_register0(msk[0]), .pattern_mask_register1(msk[1]),
        .pattern_mask_register2(msk[2]), .pattern_mask_register3(msk[3]),
        .tx_buffer_register, .tx_buffer_full, .tx_output_register,
        .tx_output_full, .rx_buffer_register, .rx_buffer_full,
        .rx_input_full, .tx_check_result, .rx_check_result,
        .tx_irq_request, .rx_irq_request, .special_comm_irq_request);

    always #25 sys_clk = ~sys_clk;

    task automatic wrap_up();
        $display("fails %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    function automatic logic [15:0] poly_select_high(logic [15:0] c, logic b);
        return {c[14:0], 1'h0} ^ ((c[15] ^ b) ? 16'h1021 : 16'h0000);
    endfunction : poly_select_high

    function automatic bit hit(logic [7:0] d);
        hit = 0;
        for (int j = 0; j < 4; j++)
            if (compare_enable[j] && ((d ^ pat[j]) & ~msk[j]) == 8'h00)
                hit = 1;
    endfunction : hit

    task automatic t_put(logic b);
        t_acc = lsb_first ? {b, t_acc[7:1]} : {t_acc[6:0], b};
        t_n++;
        if (t_n == 8) begin
            q_txo.push_back(t_acc);
            t_n = 0;
            e_ti += 1 + tx_irq_source_select;
        end
    endtask : t_put

    task automatic tx_write(logic [7:0] d);
        logic b;
        int k;
        k = 0;
        repeat (60) @(negedge sys_clk);
        while (tx_buffer_full !== 1'h0 && k < 400) begin
            @(negedge sys_clk);
            k++;
        end
        tx_buffer_wdata = d;
        tx_buffer_wr = 1'h1;
        @(negedge sys_clk);
        tx_buffer_wr = 1'h0;
        e_ti += !tx_irq_source_select;
        e_sp += hit(d);
        for (int i = 0; i < 8; i++) begin
            b = lsb_first ? d[i] : d[7 - i];
            tcrc = poly_select_high(tcrc, b);
            t_put(b);
            t_ones = b ? t_ones + 1 : 0;
            if (t_ones == 5) begin
                t_put(1'h0);
                t_ones = 0;
            end
        end
    endtask : tx_write

    task automatic rx_write(logic [7:0] d);
        logic b;
        repeat (60) @(negedge sys_clk);
        rx_input_wdata = d;
        rx_input_wr = 1'h1;
        @(negedge sys_clk);
        rx_input_wr = 1'h0;
        q_cpy.push_back(d);
        e_ri++;
        e_sp += hit(d);
        if (auto_check_reset && ((d ^ pat[3]) & ~msk[3]) == 8'h00)
            rcrc = 16'hFFFF;
        for (int i = 0; i < 8; i++) begin
            b = lsb_first ? d[i] : d[7 - i];
            if (r_ones == 5 && !b) begin
                r_ones = 0;
            end else begin
                rcrc = poly_select_high(rcrc, b);
                r_acc = lsb_first ? {b, r_acc[7:1]} : {r_acc[6:0], b};
                r_ones = !b ? 0 : (r_ones == 5 ? 5 : r_ones + 1);
                r_n++;
                if (r_n == 8) begin
                    q_rxb.push_back(r_acc);
                    r_n = 0;
                    e_ri++;
                end
            end
        end
    endtask : rx_write

    task automatic counts();
        repeat (100) @(negedge sys_clk);
        `CHK(n_ti, e_ti)
        `CHK(n_ri, e_ri)
        `CHK(n_sp, e_sp)
        `CHK(q_txo.size() + q_rxb.size(), 0)
    endtask : counts

    // result watcher: takes the oldest expected value when it reads a result; tx output is not read while hold_rd is set
    always @(negedge sys_clk) begin
        n_ti += (tx_irq_request === 1'h1);
        n_ri += (rx_irq_request === 1'h1);
        n_sp += (special_comm_irq_request === 1'h1);
        tx_output_rd = (tx_output_full === 1'h1) && !hold_rd;
        rx_buffer_rd = (rx_buffer_full === 1'h1);
        if (tx_output_rd) begin
            ev = q_txo.size() ? q_txo.pop_front() : 8'hXX;
            `CHK(tx_output_register, ev)
        end
        if (rx_buffer_rd) begin
            ev = q_rxb.size() ? q_rxb.pop_front() : 8'hXX;
            `CHK(rx_buffer_register, ev)
        end
        if (p_rif && rx_input_full === 1'h0) begin
            ev = q_cpy.size() ? q_cpy.pop_front() : 8'hXX;
            `CHK(tx_buffer_register, ev)
            `CHK(rx_irq_request, 1'h1)
        end
        if (p_tbf && tx_buffer_full === 1'h0 && !tx_irq_source_select) begin
            `CHK(tx_irq_request, 1'h1)
            `CHK(special_comm_irq_request, hit(tx_buffer_register))
        end
        p_rif = (rx_input_full === 1'h1);
        p_tbf = (tx_buffer_full === 1'h1);
    end

    initial begin
        void'($urandom(32'h0B9B));
        {tx_enable_bit, rx_enable_bit, tx_irq_source_select, lsb_first} = 0;
        {tx_buffer_wr, rx_input_wr, auto_check_reset} = 0;
        {tx_check_enable, rx_check_enable, crc_initial_value_select} = 3'h7;
        {tx_buffer_wdata, rx_input_wdata} = 16'h0000;
        poly_select = 2'h3;
        compare_enable = 4'hF;
        pat = '{8'hFF, 8'h00, 8'h5A, 8'h7E};
        msk = '{8'h01, 8'h00, 8'h00, 8'h00};
        pat[1] = 8'($urandom);
        msk[1] = 8'($urandom);
        tcrc = 16'hFFFF;
        rcrc = 16'h0000;
        repeat (10) @(negedge sys_clk);
        reset_n = 1'h1;
        tx_write(8'hA5);
        repeat (20) @(negedge sys_clk);
        `CHK(tx_buffer_full, 1'h1)
        `CHK(tx_check_result, 16'hFFFF)
        tx_enable_bit = 1'h1;
        tx_write(8'h3C);
        repeat (80) @(negedge sys_clk);
        `CHK(tx_check_result, tcrc)
        counts();
        tx_enable_bit = 1'h0;
        repeat (3) @(negedge sys_clk);
        `CHK(tx_check_result, 16'hFFFF)
        crc_initial_value_select = 1'h0;
        repeat (3) @(negedge sys_clk);
        `CHK(tx_check_result, 16'h0000)
        crc_initial_value_select = 1'h1;
        repeat (3) @(negedge sys_clk);
        {tx_enable_bit, tx_irq_source_select, lsb_first} = 3'h7;
        hold_rd = 1;
        tx_write(8'hFF);
        tx_write(8'h7E);
        repeat (100) @(negedge sys_clk);
        `CHK(tx_output_full, 1'h1)
        hold_rd = 0;
        repeat (6) tx_write(8'($urandom));
        counts();
        lsb_first = 1'h0;
        rx_write(8'h12);
        repeat (20) @(negedge sys_clk);
        `CHK(rx_input_full, 1'h1)
        rx_enable_bit = 1'h1;
        rx_write(8'h34);
        repeat (80) @(negedge sys_clk);
        `CHK(rx_check_result, rcrc)
        auto_check_reset = 1'h1;
        rx_write(8'h7E);
        repeat (80) @(negedge sys_clk);
        `CHK(rx_check_result, rcrc)
        lsb_first = 1'h1;
        rx_write(8'hFE);
        repeat (7) rx_write(8'($urandom));
        counts();
        wrap_up();
    end
endmodule : test_hdlc_data_processing_unit
